// File: hdl/chgo_pkg.sv
package chgo_pkg;
    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    // register offsets, printed values used directly as addresses
    localparam logic [7:0] ODD_GO_OFS = 8'h1f;
    localparam logic [7:0] EVEN_GO_OFS = 8'h20;
    localparam logic [7:0] LANE_HPF_OFS = 8'h21;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] READ_IDLE = 16'h0000;
    // gain/offset register layout
    localparam int GAIN_MSB = 15;
    localparam int GAIN_LSB = 11;
    localparam int RSVD_GO_BIT = 10;
    localparam int OFS_MSB = 9;
    localparam int OFS_LSB = 0;
    // lane pattern / high-pass register layout
    localparam int PRBS5_BIT = 15;
    localparam int PAT5_MSB = 11;
    localparam int PAT5_LSB = 9;
    localparam int PAT6_MSB = 8;
    localparam int PAT6_LSB = 6;
    localparam int RSVD_LH_BIT = 5;
    localparam int K_MSB = 4;
    localparam int K_LSB = 1;
    localparam int HPF_EN_BIT = 0;
    // field widths
    localparam int SAMPLE_W = 14;
    localparam int GAIN_W = 5;
    localparam int OFFSET_W = 10;
    localparam int PAT_W = 3;
    localparam int K_W = 4;
    localparam int LANES = 4;
    // gain factor, unsigned fixed point with GAIN_FRAC fraction bits
    localparam int FACTOR_W = 16;
    localparam int GAIN_FRAC = 12;
    localparam logic [15:0] GAIN_UNITY = 16'h1000;
    // one 0.2 dB step, 10^(0.01) scaled by 4096
    localparam logic [15:0] GAIN_STEP = 16'h105f;
endpackage : chgo_pkg

// File: hdl/chgo_dp_if.sv
`timescale 1ns/100ps
interface chgo_dp_if
    import chgo_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int GW = GAIN_W,
    parameter int OW = OFFSET_W
);
    logic [GW-1:0] gain_code;
    logic [OW-1:0] offset;
    logic gain_en;
    logic offset_en;
    logic in_valid;
    logic signed [SW-1:0] in_sample;
    logic out_valid;
    logic signed [SW-1:0] out_sample;

    // register bank side
    modport ctrl(output gain_code, offset, gain_en, offset_en, in_valid,
        in_sample, input out_valid, out_sample);
    // sample processor side
    modport proc(input gain_code, offset, gain_en, offset_en, in_valid,
        in_sample, output out_valid, out_sample);
endinterface : chgo_dp_if

// File: hdl/chgo_lane_qual.sv
`timescale 1ns/100ps
module chgo_lane_qual
    import chgo_pkg::*;
#(
    parameter int PW = PAT_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic mode_i,
    input wire logic prbs_i,
    input wire logic [PW-1:0] pat_i,
    output logic prbs_o,
    output logic [PW-1:0] pat_o
);
    typedef struct packed {
        logic prbs;
        logic [PW-1:0] pat;
    } chgo_lane_t;

    chgo_lane_t st_reg;
    chgo_lane_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // lane fields pass only in per-lane pattern mode
    always_comb begin
        st_next = st_reg;
        st_next.prbs = mode_i & prbs_i;
        st_next.pat = mode_i ? pat_i : '0;
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prbs_o = st_reg.prbs;
    assign pat_o = st_reg.pat;
endmodule : chgo_lane_qual

// File: hdl/chgo_offset_gain.sv
`timescale 1ns/100ps
module chgo_offset_gain
    import chgo_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int GW = GAIN_W,
    parameter int OW = OFFSET_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    chgo_dp_if.proc dp
);
    localparam int FW = FACTOR_W;
    localparam int PW = SW + FW + 1;
    localparam int STEPS = (1 << GW) - 1;

    typedef struct packed {
        logic v1;
        logic signed [SW-1:0] s1;
        logic [FW-1:0] f1;
        logic v2;
        logic signed [SW-1:0] s2;
    } chgo_dp_t;

    chgo_dp_t st_reg;
    chgo_dp_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // code n to linear factor, n steps of 0.2 dB from unity
    function automatic logic [FW-1:0] gain_factor(input logic [GW-1:0] n);
        logic [31:0] acc;
        acc = {16'h0000, GAIN_UNITY};
        for (int i = 0; i < STEPS; i++) begin
            if (i < int'(n)) begin
                acc = (acc * {16'h0000, GAIN_STEP}) >> GAIN_FRAC;
            end
        end
        return acc[FW-1:0];
    endfunction : gain_factor

    ////////////////////////////////////////////////////////////////////////
    // stage 1 offset subtract, stage 2 gain multiply
    always_comb begin
        logic signed [SW:0] diff;
        logic signed [SW:0] ofs;
        logic signed [PW-1:0] prod;
        logic signed [PW-1:0] sh;
        logic [SW-1:0] smax;
        logic [SW-1:0] smin;
        diff = '0;
        ofs = '0;
        prod = '0;
        sh = '0;
        smax = {1'b0, {(SW-1){1'b1}}};
        smin = {1'b1, {(SW-1){1'b0}}};
        st_next = st_reg;
        // offset lsb weighs one 14-bit sample lsb, sign extended
        if (dp.offset_en) begin
            ofs = $signed({{(SW+1-OW){dp.offset[OW-1]}}, dp.offset});
        end
        diff = $signed({dp.in_sample[SW-1], dp.in_sample}) - ofs;
        st_next.v1 = dp.in_valid;
        if (diff[SW] != diff[SW-1]) begin
            st_next.s1 = diff[SW] ? $signed(smin) : $signed(smax);
        end else begin
            st_next.s1 = diff[SW-1:0];
        end
        // disabled gain gives unity
        st_next.f1 = dp.gain_en ? gain_factor(dp.gain_code) : GAIN_UNITY;
        prod = PW'(st_reg.s1) * PW'($signed({1'b0, st_reg.f1}));
        sh = prod >>> GAIN_FRAC;
        st_next.v2 = st_reg.v1;
        if (sh > $signed({{(PW-SW){1'b0}}, smax})) begin
            st_next.s2 = $signed(smax);
        end else if (sh < $signed({{(PW-SW){1'b1}}, smin})) begin
            st_next.s2 = $signed(smin);
        end else begin
            st_next.s2 = sh[SW-1:0];
        end
    end

    // pipeline register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dp.out_valid = st_reg.v2;
    assign dp.out_sample = st_reg.s2;
endmodule : chgo_offset_gain

// File: hdl/chgo_chan_cfg.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module chgo_chan_cfg
    import chgo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic global_gain_enable_i,
    input wire logic global_offset_enable_i,
    input wire logic per_lane_pattern_mode_i,
    input wire logic [PAT_W-1:0] lane7_pattern_select_i,
    input wire logic [PAT_W-1:0] lane8_pattern_select_i,
    input wire logic sample_valid_i,
    input wire logic sample_odd_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic sample_valid_o,
    output logic signed [SAMPLE_W-1:0] sample_o,
    output logic [LANES-1:0] lane_prbs_enable_o,
    output logic [LANES-1:0][PAT_W-1:0] lane_pattern_select_o,
    output logic group2_highpass_enable_o,
    output logic [K_W-1:0] group2_highpass_corner_k_o
);
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] ch8_odd_gain_offset;
        logic [DATA_W-1:0] ch8_even_gain_offset;
        logic [DATA_W-1:0] lane_pattern_hpf_ctrl;
        logic hpf_en;
        logic [K_W-1:0] hpf_k;
    } chgo_state_t;

    chgo_state_t st_reg;
    chgo_state_t st_next;
    logic [LANES-1:0] prbs_src;
    logic [LANES-1:0][PAT_W-1:0] pat_src;

    chgo_dp_if #(
        .SW(SAMPLE_W),
        .GW(GAIN_W),
        .OW(OFFSET_W)
    ) dp ();

    ////////////////////////////////////////////////////////////////////////
    // register writes, read data and filter controls
    always_comb begin
        st_next = st_reg;
        st_next.rdata = READ_IDLE;
        // full-word writes; reserved bits are kept as written
        if (reg_wr_i) begin
            case (reg_addr_i)
                ODD_GO_OFS: begin
                    st_next.ch8_odd_gain_offset = reg_wdata_i;
                end
                EVEN_GO_OFS: begin
                    st_next.ch8_even_gain_offset = reg_wdata_i;
                end
                LANE_HPF_OFS: begin
                    st_next.lane_pattern_hpf_ctrl = reg_wdata_i;
                end
                default: begin
                    st_next.rdata = READ_IDLE;
                end
            endcase
        end
        // read data stand one cycle, zero for unmapped addresses
        if (reg_rd_i) begin
            case (reg_addr_i)
                ODD_GO_OFS: begin
                    st_next.rdata = st_reg.ch8_odd_gain_offset;
                end
                EVEN_GO_OFS: begin
                    st_next.rdata = st_reg.ch8_even_gain_offset;
                end
                LANE_HPF_OFS: begin
                    st_next.rdata = st_reg.lane_pattern_hpf_ctrl;
                end
                default: begin
                    st_next.rdata = READ_IDLE;
                end
            endcase
        end
        // filter enable and corner, k passed as stored while enabled, zero otherwise
        st_next.hpf_en = st_reg.lane_pattern_hpf_ctrl[HPF_EN_BIT];
        if (st_reg.lane_pattern_hpf_ctrl[HPF_EN_BIT]) begin
            st_next.hpf_k = st_reg.lane_pattern_hpf_ctrl[K_MSB:K_LSB];
        end else begin
            st_next.hpf_k = '0;
        end
    end

    // state register, all zero at reset
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-sample field selection by sample parity
    assign dp.in_valid = sample_valid_i;
    assign dp.in_sample = sample_i;
    assign dp.gain_en = global_gain_enable_i;
    assign dp.offset_en = global_offset_enable_i;
    assign dp.gain_code = sample_odd_i ?
        st_reg.ch8_odd_gain_offset[GAIN_MSB:GAIN_LSB] :
        st_reg.ch8_even_gain_offset[GAIN_MSB:GAIN_LSB];
    assign dp.offset = sample_odd_i ?
        st_reg.ch8_odd_gain_offset[OFS_MSB:OFS_LSB] :
        st_reg.ch8_even_gain_offset[OFS_MSB:OFS_LSB];

    // offset and gain pipeline, two cycles
    chgo_offset_gain #(
        .SW(SAMPLE_W),
        .GW(GAIN_W),
        .OW(OFFSET_W)
    ) u_offset_gain (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .dp(dp.proc)
    );

    assign sample_valid_o = dp.out_valid;
    assign sample_o = dp.out_sample;

    ////////////////////////////////////////////////////////////////////////
    // lane sources: 5 and 6 select here, 7 and 8 select held elsewhere
    assign pat_src[0] = st_reg.lane_pattern_hpf_ctrl[PAT5_MSB:PAT5_LSB];
    assign pat_src[1] = st_reg.lane_pattern_hpf_ctrl[PAT6_MSB:PAT6_LSB];
    assign pat_src[2] = lane7_pattern_select_i;
    assign pat_src[3] = lane8_pattern_select_i;

    // one qualifier per lane
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign prbs_src[g] = st_reg.lane_pattern_hpf_ctrl[PRBS5_BIT-g];
        chgo_lane_qual #(
            .PW(PAT_W)
        ) u_lane (
            .clk_i(clk_i),
            .rstn_i(rstn_i),
            .mode_i(per_lane_pattern_mode_i),
            .prbs_i(prbs_src[g]),
            .pat_i(pat_src[g]),
            .prbs_o(lane_prbs_enable_o[g]),
            .pat_o(lane_pattern_select_o[g])
        );
    end

    assign reg_rdata_o = st_reg.rdata;
    assign group2_highpass_enable_o = st_reg.hpf_en;
    assign group2_highpass_corner_k_o = st_reg.hpf_k;
endmodule : chgo_chan_cfg

// File: test/chgo_chan_cfg_chk.sv
`timescale 1ns/100ps
module chgo_chan_cfg_chk
    import chgo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic global_gain_enable_i,
    input wire logic global_offset_enable_i,
    input wire logic per_lane_pattern_mode_i,
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    input wire logic sample_valid_o,
    input wire logic signed [SAMPLE_W-1:0] sample_o,
    input wire logic [LANES-1:0] lane_prbs_enable_o,
    input wire logic [LANES-1:0][PAT_W-1:0] lane_pattern_select_o,
    input wire logic group2_highpass_enable_o,
    input wire logic [K_W-1:0] group2_highpass_corner_k_o
);
    // single clock domain, async reset
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // address hits one of the three registers
    wire logic mapped = reg_addr_i inside {ODD_GO_OFS, EVEN_GO_OFS,
        LANE_HPF_OFS};
    // bus steps
    sequence s_go_wr;
        reg_wr_i && mapped;
    endsequence
    sequence s_lane_wr;
        reg_wr_i && reg_addr_i == LANE_HPF_OFS;
    endsequence
    ////////////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not idle");
    AST_RD_UNMAPPED: assert property (reg_rd_i && !mapped |=>
        reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    AST_WR_RD: assert property (s_go_wr ##1 (reg_rd_i &&
        $stable(reg_addr_i)) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("read after write wrong");
    AST_VALID_LAT: assert property (sample_valid_i |-> ##2 sample_valid_o)
        else $error("sample valid latency");
    AST_BYPASS: assert property (sample_valid_i && !global_gain_enable_i
        && !global_offset_enable_i |-> ##2 sample_o == $past(sample_i, 2))
        else $error("sample altered with enables off");
    AST_MODE_OFF: assert property (!per_lane_pattern_mode_i |=>
        lane_prbs_enable_o == 4'h0 && lane_pattern_select_o == 12'h000)
        else $error("lane fields leak in common mode");
    AST_LANE5: assert property (s_lane_wr ##1 per_lane_pattern_mode_i |=>
        lane_prbs_enable_o[0] == $past(reg_wdata_i[PRBS5_BIT], 2) &&
        lane_pattern_select_o[0] == $past(reg_wdata_i[PAT5_MSB:PAT5_LSB], 2))
        else $error("lane 5 fields wrong");
    AST_HPF_EN: assert property (s_lane_wr |-> ##2
        group2_highpass_enable_o == $past(reg_wdata_i[HPF_EN_BIT], 2))
        else $error("filter enable wrong");
    AST_K_GATE: assert property (group2_highpass_corner_k_o != 4'h0 |->
        group2_highpass_enable_o) else $error("corner k while filter off");
endmodule : chgo_chan_cfg_chk

bind chgo_chan_cfg chgo_chan_cfg_chk chgo_chan_cfg_chk_i (.*);

// File: test/chgo_chan_cfg_bench.sv
`timescale 1ns/100ps
module chgo_chan_cfg_bench
    import chgo_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = 8'h00;
    logic [DATA_W-1:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, sample_valid_i = 1'b0;
    logic global_gain_enable_i = 1'b0, global_offset_enable_i = 1'b0;
    logic per_lane_pattern_mode_i = 1'b0, sample_odd_i = 1'b0;
    logic [PAT_W-1:0] lane7_pattern_select_i = 3'h5;
    logic [PAT_W-1:0] lane8_pattern_select_i = 3'h2;
    logic signed [SAMPLE_W-1:0] sample_i = 14'h0000, sample_o;
    logic [DATA_W-1:0] reg_rdata_o;
    logic sample_valid_o, group2_highpass_enable_o;
    logic [LANES-1:0] lane_prbs_enable_o;
    logic [LANES-1:0][PAT_W-1:0] lane_pattern_select_o;
    logic [K_W-1:0] group2_highpass_corner_k_o;
    int n_mismatch = 0, total_checks = 0;

    chgo_chan_cfg chgo_chan_cfg_i (.*);

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // tasks start and end just after a rising edge
    task automatic wr(logic [7:0] a, logic [15:0] d);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [15:0] exp);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk("rdata", exp, reg_rdata_o);
        @(posedge clk_i);
    endtask : rd
    function automatic logic signed [31:0] sat(logic signed [31:0] v);
        return v > 8191 ? 32'sd8191 : (v < -8192 ? -32'sd8192 : v);
    endfunction : sat
    // reference: offset, gain loop truncated per step, saturation
    function automatic logic [15:0] m(logic signed [13:0] s, logic [4:0] n,
        logic [9:0] o, logic ge, logic oe);
        logic [31:0] f;
        logic signed [31:0] d;
        f = 32'h1000;
        d = s;
        if (ge) for (int i = 0; i < n; i++) f = (f * GAIN_STEP) >> 12;
        if (oe) d = sat(d - $signed({{22{o[9]}}, o}));
        d = sat((d * $signed(f)) >>> 12);
        return d[15:0];
    endfunction : m
    task automatic smp(logic odd, logic [1:0] en, logic signed [13:0] s,
        logic [4:0] n, logic [9:0] o);
        sample_valid_i <= 1'b1;
        sample_odd_i <= odd;
        {global_offset_enable_i, global_gain_enable_i} <= en;
        sample_i <= s;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        // result stands in the cycle after the second pipeline edge
        @(posedge clk_i);
        #1 chk("sample", m(s, n, o, en[0], en[1]), 16'(sample_o));
        chk("valid", 16'h0001, {15'h0000, sample_valid_o});
        @(posedge clk_i);
    endtask : smp
    task automatic lanes(logic [3:0] p, logic [11:0] s, logic h, logic [3:0] k);
        repeat (2) @(posedge clk_i);
        #1 chk("prbs", {12'h000, p}, {12'h000, lane_prbs_enable_o});
        chk("pat", {4'h0, s}, {4'h0, lane_pattern_select_o});
        chk("hpf", {11'h000, h, k}, {11'h000, group2_highpass_enable_o,
            group2_highpass_corner_k_o});
        @(posedge clk_i);
    endtask : lanes
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        // reserved bits written as zero
        wr(ODD_GO_OFS, 16'hf805);
        rd(ODD_GO_OFS, 16'hf805);
        wr(EVEN_GO_OFS, 16'h03fe);
        rd(EVEN_GO_OFS, 16'h03fe);
        wr(8'h22, 16'hffff);
        rd(8'h22, 16'h0000);
        rd(ODD_GO_OFS, 16'hf805);
    endtask : t_regs
    task automatic t_dsp();
        wr(ODD_GO_OFS, {5'd5, 1'b0, 10'h3fd});
        // let an edge pass so the strobe is not set twice at once
        @(posedge clk_i);
        wr(EVEN_GO_OFS, {5'd31, 1'b0, 10'd100});
        for (int k = 0; k < 4; k++) begin
            smp(1'b1, 2'(k), 14'sd8191, 5'd5, 10'h3fd);
            smp(1'b1, 2'(k), -14'sd700, 5'd5, 10'h3fd);
            smp(1'b0, 2'(k), -14'sd5000, 5'd31, 10'd100);
            smp(1'b0, 2'(k), 14'sd300, 5'd31, 10'd100);
        end
    endtask : t_dsp
    task automatic t_lanes();
        logic [15:0] tbl[3] = '{16'h0005, 16'h0015, 16'ha74b};
        wr(LANE_HPF_OFS, 16'ha74a);
        lanes(4'h0, 12'h000, 1'b0, 4'h0);
        per_lane_pattern_mode_i <= 1'b1;
        lanes(4'h5, {3'h2, 3'h5, 3'h5, 3'h3}, 1'b0, 4'h0);
        // corner values kept within 2..10
        foreach (tbl[i]) begin
            wr(LANE_HPF_OFS, tbl[i]);
            lanes(tbl[i][15:12] == 4'ha ? 4'h5 : 4'h0, {3'h2, 3'h5,
                tbl[i][8:6], tbl[i][11:9]}, 1'b1, tbl[i][4:1]);
        end
    endtask : t_lanes
    // main sequence: reset, reset values, scenarios
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int a = 31; a <= 33; a++) rd(8'(a), REG_RESET);
        t_regs();
        t_dsp();
        t_lanes();
        finish_test();
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
endmodule : chgo_chan_cfg_bench
